// ### rtl/hpm_pkg.sv
// shared constants and types for the halt power mode controller
package hpm_pkg;
   localparam int unsigned PORTA_W         = 8;
   localparam int unsigned IRQ_W           = 8;
   localparam int unsigned CLK_PERIOD_NS   = 100;
   // fast oscillator restart settle time in ns
   localparam int unsigned FAST_SETTLE_NS  = 1600;
   localparam int unsigned FAST_SETTLE_CYC =
      (FAST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_W        = 8;
   localparam logic        PDF_RST         = 1'b0;
   localparam logic        TOF_RST         = 1'b0;
   localparam logic        FSTAB_RST       = 1'b1;

   // power modes, run plus four halt modes, and the wake wait state
   typedef enum logic [2:0] {
      HPM_RUN,
      HPM_SLEEP,
      HPM_IDLE_SLOW,
      HPM_IDLE_BOTH,
      HPM_IDLE_FAST,
      HPM_WAKE_WAIT
   } hpm_state_t;

   // wake cause
   typedef enum logic [1:0] {
      HPM_WK_NONE,
      HPM_WK_PIN,
      HPM_WK_IRQ,
      HPM_WK_WDT
   } hpm_cause_t;
endpackage

// ### rtl/hpm_wake_if.sv
// wake event bundle between detector and controller
`timescale 1ns/1ps
`default_nettype none
interface hpm_wake_if;
   logic pin_wake;
   logic irq_wake;
   logic wdt_wake;
   logic arm;
   modport det (output pin_wake, output irq_wake, output wdt_wake, input arm);
   modport ctl (input pin_wake, input irq_wake, input wdt_wake, output arm);
endinterface
`default_nettype wire

// ### rtl/hpm_wake_det.sv
// synchronises wake sources and flags qualifying wake events
`timescale 1ns/1ps
`default_nettype none
module hpm_wake_det
(
   // clock and reset
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rstn,
   // raw sources
   input  wire logic [hpm_pkg::PORTA_W-1:0] i_porta,
   input  wire logic [hpm_pkg::PORTA_W-1:0] i_wake_mask,
   input  wire logic [hpm_pkg::IRQ_W-1:0]   i_irq_req,
   input  wire logic                        i_wdt_ovf,
   // to controller
   hpm_wake_if.det                          wk
);
   logic [hpm_pkg::PORTA_W-1:0] pa_s1_r;
   logic [hpm_pkg::PORTA_W-1:0] pa_s2_r;
   logic [hpm_pkg::PORTA_W-1:0] pa_d_r;
   logic [hpm_pkg::IRQ_W-1:0]   irq_s1_r;
   logic [hpm_pkg::IRQ_W-1:0]   irq_s2_r;
   logic [hpm_pkg::IRQ_W-1:0]   irq_pre_r;
   logic                        wdt_s1_r;
   logic                        wdt_s2_r;
   logic                        arm_d_r;
   logic [hpm_pkg::PORTA_W-1:0] pa_fall;

   // two-stage synchronisers, first stage read only by the second
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pa_s1_r  <= '1;
         pa_s2_r  <= '1;
         pa_d_r   <= '1;
         irq_s1_r <= '0;
         irq_s2_r <= '0;
         wdt_s1_r <= 1'b0;
         wdt_s2_r <= 1'b0;
         arm_d_r  <= 1'b0;
         irq_pre_r <= '0;
      end
      else
      begin
         pa_s1_r  <= i_porta;
         pa_s2_r  <= pa_s1_r;
         pa_d_r   <= pa_s2_r;
         irq_s1_r <= i_irq_req;
         irq_s2_r <= irq_s1_r;
         wdt_s1_r <= i_wdt_ovf;
         wdt_s2_r <= wdt_s1_r;
         arm_d_r  <= wk.arm;
         // capture requests already pending at power-down entry
         if (wk.arm && !arm_d_r)
            irq_pre_r <= irq_s2_r;
         else if (!wk.arm)
            irq_pre_r <= '0;
      end
   end

   // per-pin falling edge, gated by its own wake enable
   genvar g;
   generate
      for (g = 0; g < hpm_pkg::PORTA_W; g++)
      begin : g_pin
         assign pa_fall[g] = i_wake_mask[g] & pa_d_r[g] & ~pa_s2_r[g];
      end
   endgenerate

   // only fresh interrupt requests wake; pre-set request flags are excluded, the watchdog overflow wakes on its level
   assign wk.pin_wake = wk.arm & (|pa_fall);
   assign wk.irq_wake = wk.arm & (|(irq_s2_r & ~irq_pre_r)) & arm_d_r;
   assign wk.wdt_wake = wk.arm & wdt_s2_r;
endmodule
`default_nettype wire

// ### rtl/hpm_settle.sv
// fast oscillator stable flag: clears while disabled and on enable, sets after settle time
`timescale 1ns/1ps
`default_nettype none
module hpm_settle
(
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rstn,
   // oscillator enable
   input  wire logic i_osc_en,
   // stable flag
   output logic      o_stable
);
   localparam logic [hpm_pkg::SETTLE_W-1:0] SETTLE_CNT =
      hpm_pkg::SETTLE_W'(hpm_pkg::FAST_SETTLE_CYC);

   logic [hpm_pkg::SETTLE_W-1:0] cnt_r;
   logic                         en_d_r;
   logic                         stable_r;
   wire                          en_rise = i_osc_en & ~en_d_r;

   // restart clears the flag first, then counts settle cycles
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cnt_r    <= '0;
         en_d_r   <= 1'b1;
         stable_r <= hpm_pkg::FSTAB_RST;
      end
      else
      begin
         en_d_r <= i_osc_en;
         if (!i_osc_en || en_rise)
         begin
            stable_r <= 1'b0;
            cnt_r    <= '0;
         end
         else if (!stable_r)
         begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == SETTLE_CNT - 1'b1)
               stable_r <= 1'b1;
         end
      end
   end

   assign o_stable = stable_r;

   a_settle_time: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      en_rise |=> !o_stable [*8]) else $error("stable flag set too early");
endmodule
`default_nettype wire

// ### rtl/hpm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module hpm_ctrl
(
   // clock and reset
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rstn,
   // core instruction strobes
   input  wire logic                        i_halt_exec,
   input  wire logic                        i_watchdog_clear_instruction,
   // system clock control bits
   input  wire logic                        i_fast_osc_keep_on_halt,
   input  wire logic                        i_slow_osc_keep_on_halt,
   input  wire logic                        i_wdt_enable,
   // wake sources
   input  wire logic [hpm_pkg::PORTA_W-1:0] i_porta,
   input  wire logic [hpm_pkg::PORTA_W-1:0] i_porta_wake_enable_mask,
   input  wire logic [hpm_pkg::IRQ_W-1:0]   i_irq_req,
   input  wire logic [hpm_pkg::IRQ_W-1:0]   i_irq_enable,
   input  wire logic                        i_stack_full,
   input  wire logic                        i_wdt_ovf,
   // core control
   output logic                             o_core_halt,
   output logic                             o_resume_next,
   output logic                             o_take_irq,
   output logic                             o_pc_sp_reset,
   output logic                             o_hold_state,
   // clocks and watchdog
   output logic                             o_fast_clk_en,
   output logic                             o_slow_clk_en,
   output logic                             o_wdt_clear,
   // status flags
   output logic                             o_power_down_flag,
   output logic                             o_watchdog_timeout_flag,
   output logic                             o_fast_osc_stable_flag,
   output logic [2:0]                       o_mode
);
   hpm_wake_if wk ();

   hpm_pkg::hpm_state_t state_r;
   hpm_pkg::hpm_state_t state_nxt;
   hpm_pkg::hpm_cause_t cause_r;
   hpm_pkg::hpm_cause_t cause_nxt;
   logic                pdf_r;
   logic                tof_r;
   logic                halt_r;
   logic                resume_r;
   logic                take_irq_r;
   logic                pcsp_r;
   logic                wdtclr_r;
   logic                fast_en_r;
   logic                slow_en_r;
   logic                fast_stable;
   logic                any_wake;
   logic                halted;
   logic                irq_serviceable;
   logic                leave_wait;
   logic [hpm_pkg::IRQ_W-1:0] irq_s1_r;
   logic [hpm_pkg::IRQ_W-1:0] irq_s2_r;
   logic [hpm_pkg::IRQ_W-1:0] irq_en_r;
   logic                sfull_r;

   hpm_wake_det u_det
   (
      .i_core_clk  (i_core_clk),
      .i_rstn      (i_rstn),
      .i_porta     (i_porta),
      .i_wake_mask (i_porta_wake_enable_mask),
      .i_irq_req   (i_irq_req),
      .i_wdt_ovf   (i_wdt_ovf),
      .wk          (wk)
   );

   hpm_settle u_settle
   (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_osc_en   (fast_en_r),
      .o_stable   (fast_stable)
   );

   // halted states and wake decode; core waits until a wake arrives
   assign halted    = (state_r == hpm_pkg::HPM_SLEEP) || (state_r == hpm_pkg::HPM_IDLE_SLOW)
                   || (state_r == hpm_pkg::HPM_IDLE_BOTH) || (state_r == hpm_pkg::HPM_IDLE_FAST);
   assign wk.arm    = halted;
   assign any_wake  = wk.pin_wake | wk.irq_wake | wk.wdt_wake;
   // interrupt gets its vector only if enabled and stack has room
   assign irq_serviceable = (|(irq_s2_r & irq_en_r)) & ~sfull_r;
   // resume only after the fast oscillator reports stable
   assign leave_wait = (state_r == hpm_pkg::HPM_WAKE_WAIT) && fast_stable;

   // next state: mode chosen by the two keep-on bits at halt
   always_comb
   begin
      state_nxt = state_r;
      cause_nxt = cause_r;
      case (state_r)
         hpm_pkg::HPM_RUN:
            if (i_halt_exec)
            begin
               case ({i_fast_osc_keep_on_halt, i_slow_osc_keep_on_halt})
                  2'b00:   state_nxt = hpm_pkg::HPM_SLEEP;
                  2'b01:   state_nxt = hpm_pkg::HPM_IDLE_SLOW;
                  2'b11:   state_nxt = hpm_pkg::HPM_IDLE_BOTH;
                  default: state_nxt = hpm_pkg::HPM_IDLE_FAST;
               endcase
            end
         hpm_pkg::HPM_SLEEP,
         hpm_pkg::HPM_IDLE_SLOW,
         hpm_pkg::HPM_IDLE_BOTH,
         hpm_pkg::HPM_IDLE_FAST:
            if (any_wake)
            begin
               state_nxt = hpm_pkg::HPM_WAKE_WAIT;
               // watchdog has priority, then interrupt, then pin
               if (wk.wdt_wake)
                  cause_nxt = hpm_pkg::HPM_WK_WDT;
               else if (wk.irq_wake)
                  cause_nxt = hpm_pkg::HPM_WK_IRQ;
               else
                  cause_nxt = hpm_pkg::HPM_WK_PIN;
            end
         hpm_pkg::HPM_WAKE_WAIT:
            if (fast_stable)
            begin
               state_nxt = hpm_pkg::HPM_RUN;
               cause_nxt = hpm_pkg::HPM_WK_NONE;
            end
         default:
            state_nxt = hpm_pkg::HPM_RUN;
      endcase
   end

   // state, flags and core strobes
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_r    <= hpm_pkg::HPM_RUN;
         cause_r    <= hpm_pkg::HPM_WK_NONE;
         pdf_r      <= hpm_pkg::PDF_RST;
         tof_r      <= hpm_pkg::TOF_RST;
         halt_r     <= 1'b0;
         resume_r   <= 1'b0;
         take_irq_r <= 1'b0;
         pcsp_r     <= 1'b0;
         wdtclr_r   <= 1'b0;
         irq_s1_r   <= '0;
         irq_s2_r   <= '0;
         irq_en_r   <= '0;
         sfull_r    <= 1'b0;
      end
      else
      begin
         state_r  <= state_nxt;
         cause_r  <= cause_nxt;
         irq_s1_r <= i_irq_req;
         irq_s2_r <= irq_s1_r;
         irq_en_r <= i_irq_enable;
         sfull_r  <= i_stack_full;
         // core stays stopped from halt until the oscillator settles
         halt_r   <= (state_nxt != hpm_pkg::HPM_RUN);
         wdtclr_r <= (state_r == hpm_pkg::HPM_RUN) && i_halt_exec;
         if ((state_r == hpm_pkg::HPM_RUN) && i_halt_exec)
         begin
            pdf_r <= 1'b1;
            tof_r <= 1'b0;
         end
         else if (halted && wk.wdt_wake)
            tof_r <= 1'b1;
         else if (i_watchdog_clear_instruction)
            pdf_r <= 1'b0;
         resume_r   <= leave_wait && ((cause_r == hpm_pkg::HPM_WK_PIN)
                    || ((cause_r == hpm_pkg::HPM_WK_IRQ) && !irq_serviceable));
         take_irq_r <= leave_wait && (cause_r == hpm_pkg::HPM_WK_IRQ)
                    && irq_serviceable;
         pcsp_r     <= leave_wait && (cause_r == hpm_pkg::HPM_WK_WDT);
      end
   end

   // clock gates follow the halt mode
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         fast_en_r <= 1'b1;
         slow_en_r <= 1'b1;
      end
      else
      begin
         fast_en_r <= !((state_nxt == hpm_pkg::HPM_SLEEP)
                    || (state_nxt == hpm_pkg::HPM_IDLE_SLOW));
         // the watchdog needs its slow clock even when keep-on is low
         slow_en_r <= !(((state_nxt == hpm_pkg::HPM_SLEEP)
                    || (state_nxt == hpm_pkg::HPM_IDLE_FAST)) && !i_wdt_enable);
      end
   end

   assign o_core_halt             = halt_r;
   assign o_hold_state            = halt_r;
   assign o_resume_next           = resume_r;
   assign o_take_irq              = take_irq_r;
   assign o_pc_sp_reset           = pcsp_r;
   assign o_fast_clk_en           = fast_en_r;
   assign o_slow_clk_en           = slow_en_r;
   assign o_wdt_clear             = wdtclr_r;
   assign o_power_down_flag       = pdf_r;
   assign o_watchdog_timeout_flag = tof_r;
   assign o_fast_osc_stable_flag  = fast_stable;
   assign o_mode                  = state_r;

   a_halt_sets_pdf: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_RUN && i_halt_exec) |=> (o_power_down_flag && !o_watchdog_timeout_flag))
      else $error("halt did not set pdf and clear to");
   a_sleep_entry: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_RUN && i_halt_exec && !i_fast_osc_keep_on_halt
       && !i_slow_osc_keep_on_halt) |=> (state_r == hpm_pkg::HPM_SLEEP) && !o_fast_clk_en)
      else $error("sleep not entered");
   a_idle_slow: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_RUN && i_halt_exec && !i_fast_osc_keep_on_halt
       && i_slow_osc_keep_on_halt) |=> (state_r == hpm_pkg::HPM_IDLE_SLOW) && o_slow_clk_en)
      else $error("idle slow not entered");
   a_idle_both: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_RUN && i_halt_exec && i_fast_osc_keep_on_halt
       && i_slow_osc_keep_on_halt) |=> (state_r == hpm_pkg::HPM_IDLE_BOTH) && o_fast_clk_en)
      else $error("idle both not entered");
   a_idle_fast: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_RUN && i_halt_exec && i_fast_osc_keep_on_halt
       && !i_slow_osc_keep_on_halt) |=> (state_r == hpm_pkg::HPM_IDLE_FAST))
      else $error("idle fast not entered");
   a_wdt_cleared: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_RUN && i_halt_exec) |=> o_wdt_clear ##1 !o_wdt_clear)
      else $error("watchdog not cleared once");
   a_wdt_wake_to: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (halted && wk.wdt_wake) |=> o_watchdog_timeout_flag)
      else $error("time-out flag not set");
   a_no_run_unstable: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_WAKE_WAIT && !fast_stable) |=> o_core_halt)
      else $error("core released before stable");
   a_slow_for_wdt: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (halted && i_wdt_enable && $stable(i_wdt_enable)) |-> o_slow_clk_en)
      else $error("slow clock off with watchdog");
   a_halt_holds: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (halted && !any_wake) |=> halted)
      else $error("left halt without wake");

   // release pulses must match the recorded wake cause
   a_pin_resume: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (leave_wait && cause_r == hpm_pkg::HPM_WK_PIN) |=> (o_resume_next && !o_take_irq))
      else $error("pin wake did not resume after halt");
   a_irq_vector: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (leave_wait && cause_r == hpm_pkg::HPM_WK_IRQ && irq_serviceable)
      |=> (o_take_irq && !o_resume_next))
      else $error("serviceable interrupt not vectored");
   a_irq_deferred: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (leave_wait && cause_r == hpm_pkg::HPM_WK_IRQ && !irq_serviceable)
      |=> (o_resume_next && !o_take_irq))
      else $error("deferred interrupt did not resume");
   a_wdt_pcsp: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (leave_wait && cause_r == hpm_pkg::HPM_WK_WDT) |=> (o_pc_sp_reset && !o_resume_next))
      else $error("watchdog wake did not reset pc");
   a_release_once: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      o_resume_next |=> !o_resume_next)
      else $error("resume pulse too long");
   a_stay_wait: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_WAKE_WAIT && !fast_stable) |=> (state_r == hpm_pkg::HPM_WAKE_WAIT))
      else $error("left wake wait before stable");

   // flag and clock gate checks, in run and while halted
   a_pdf_clear: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_RUN && !i_halt_exec && i_watchdog_clear_instruction)
      |=> !o_power_down_flag)
      else $error("clear watchdog left power-down set");
   a_halt_ignored: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r != hpm_pkg::HPM_RUN && i_halt_exec) |=> !o_wdt_clear)
      else $error("halt taken outside run");
   a_sleep_fast_off: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_SLEEP) |-> !o_fast_clk_en)
      else $error("fast clock on in sleep");
   a_both_clocks_on: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_IDLE_BOTH) |-> (o_fast_clk_en && o_slow_clk_en))
      else $error("clock off in idle both");
   a_fast_idle_slow: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_r == hpm_pkg::HPM_IDLE_FAST && !i_wdt_enable && $stable(i_wdt_enable))
      |-> (o_fast_clk_en && !o_slow_clk_en))
      else $error("wrong clocks in idle fast");
endmodule
`default_nettype wire

// ### dv/hpm_core_model.sv
// behavioural processor core: issues halt and tracks its program counter
`timescale 1ns/1ps
`default_nettype none
module hpm_core_model
#(
   parameter logic [7:0] VEC_ADDR = 8'h04
)
(
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rstn,
   // bench command
   input  wire logic       i_halt_cmd,
   // controller answers
   input  wire logic       i_core_halt,
   input  wire logic       i_resume_next,
   input  wire logic       i_take_irq,
   input  wire logic       i_pc_sp_reset,
   // core side
   output logic            o_halt_exec,
   output logic [7:0]      o_pc
);
   logic [7:0] halt_pc_r;
   logic       wait_r;

   // a real core reaches halt whenever the program says so, halted or not
   assign o_halt_exec = i_halt_cmd;

   // counter freezes from the halt edge, since o_core_halt rises one edge late
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_pc      <= 8'h10;
         halt_pc_r <= 8'h00;
         wait_r    <= 1'b0;
      end
      else if (i_pc_sp_reset || i_take_irq || i_resume_next)
      begin
         wait_r <= 1'b0;
         o_pc   <= i_pc_sp_reset ? 8'h00 : (i_take_irq ? VEC_ADDR : halt_pc_r + 8'h01);
      end
      else if (o_halt_exec && !i_core_halt)
      begin
         wait_r    <= 1'b1;
         halt_pc_r <= o_pc;
      end
      else if (!wait_r)
         o_pc <= o_pc + 8'h01;
   end
endmodule
`default_nettype wire

// ### dv/hpm_ctrl_tb.sv
// self-checking bench for the halt power mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module hpm_ctrl_tb;
   logic       clk        = 1'b0;
   logic       rstn       = 1'b0;
   logic       halt_cmd   = 1'b0;
   logic       clrwdt     = 1'b0;
   logic       fast_bit   = 1'b0;
   logic       slow_bit   = 1'b0;
   logic       wdt_en     = 1'b0;
   logic [7:0] porta      = 8'hff;
   logic [7:0] wmask      = 8'h00;
   logic [7:0] irq_req    = 8'h00;
   logic [7:0] irq_en     = 8'h00;
   logic       stack_full = 1'b0;
   logic       wdt_ovf    = 1'b0;
   logic       halt_exec, core_halt, resume_next, take_irq, pc_sp_reset, hold_state;
   logic       fast_en, slow_en, wdt_clear, power_down_flag, tof, stable, dip;
   logic [2:0] mode;
   logic [1:0] kind;
   logic [7:0] pc, hp;
   int         mismatches = 0;
   int         n_tests    = 0;
   int         cycles     = 0;
   int         cyc;

   // 10 MHz core clock
   always #50 clk = ~clk;

   hpm_ctrl dut (
      .i_core_clk(clk), .i_rstn(rstn), .i_halt_exec(halt_exec),
      .i_watchdog_clear_instruction(clrwdt), .i_fast_osc_keep_on_halt(fast_bit),
      .i_slow_osc_keep_on_halt(slow_bit), .i_wdt_enable(wdt_en), .i_porta(porta),
      .i_porta_wake_enable_mask(wmask), .i_irq_req(irq_req), .i_irq_enable(irq_en),
      .i_stack_full(stack_full), .i_wdt_ovf(wdt_ovf), .o_core_halt(core_halt),
      .o_resume_next(resume_next), .o_take_irq(take_irq), .o_pc_sp_reset(pc_sp_reset),
      .o_hold_state(hold_state), .o_fast_clk_en(fast_en), .o_slow_clk_en(slow_en),
      .o_wdt_clear(wdt_clear), .o_power_down_flag(power_down_flag), .o_watchdog_timeout_flag(tof),
      .o_fast_osc_stable_flag(stable), .o_mode(mode));

   hpm_core_model u_core (
      .i_core_clk(clk), .i_rstn(rstn), .i_halt_cmd(halt_cmd), .i_core_halt(core_halt),
      .i_resume_next(resume_next), .i_take_irq(take_irq), .i_pc_sp_reset(pc_sp_reset),
      .o_halt_exec(halt_exec), .o_pc(pc));

   // ends the run from the main sequence or the hang guard
   task automatic complete_run;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   // one halt instruction, called at a falling edge
   task automatic halt_in(input logic f, input logic s);
      hpm_pkg::hpm_state_t em;
      begin
         em = f ? (s ? hpm_pkg::HPM_IDLE_BOTH : hpm_pkg::HPM_IDLE_FAST)
                : (s ? hpm_pkg::HPM_IDLE_SLOW : hpm_pkg::HPM_SLEEP);
         fast_bit = f;
         slow_bit = s;
         hp = pc;
         halt_cmd = 1'b1;
         @(negedge clk);
         halt_cmd = 1'b0;
         `CHK(mode, em)
         `CHK(core_halt, 1'b1)
         `CHK(hold_state, 1'b1)
         `CHK(fast_en, f)
         `CHK(slow_en, s | wdt_en)
         `CHK(power_down_flag, 1'b1)
         `CHK(tof, 1'b0)
         `CHK(wdt_clear, 1'b1)
      end
   endtask

   // waits for the release pulse; kind 1 resume, 2 vector, 3 pc reset
   task automatic wait_wake(input logic [1:0] ek, input logic f);
      begin
         kind = 2'h0;
         dip = 1'b0;
         cyc = 0;
         while (kind == 2'h0 && cyc < 60)
         begin
            @(negedge clk);
            cyc++;
            if (stable === 1'b0)
               dip = 1'b1;
            kind = resume_next ? 2'h1 : (take_irq ? 2'h2 : (pc_sp_reset ? 2'h3 : 2'h0));
         end
         `CHK(kind, ek)
         `CHK(dip, ~f)
         `CHK(cyc >= hpm_pkg::FAST_SETTLE_CYC || f, 1'b1)
         `CHK(core_halt, 1'b0)
         `CHK(mode, hpm_pkg::HPM_RUN)
         @(negedge clk);
         `CHK(pc, ek == 2'h1 ? hp + 8'h01 : (ek == 2'h2 ? 8'h04 : 8'h00))
      end
   endtask

   // hang guard, far beyond the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         complete_run();
      end
   end

   initial
   begin
      repeat (16) @(negedge clk);
      `CHK(mode, hpm_pkg::HPM_RUN)
      `CHK({core_halt, fast_en, slow_en, power_down_flag, tof, stable}, 6'h19)
      rstn = 1'b1;
      @(negedge clk);
      end_test("reset");
      // every halt mode; a masked pin and a second halt must not disturb it
      for (int i = 0; i < 4; i++)
      begin
         wmask = 8'h01 << i;
         halt_in(i[1], i[0]);
         porta[i + 4] = 1'b0;
         repeat (8) @(negedge clk);
         `CHK(core_halt, 1'b1)
         halt_cmd = 1'b1;
         @(negedge clk);
         `CHK(wdt_clear, 1'b0)
         halt_cmd = 1'b0;
         porta[i] = 1'b0;
         wait_wake(2'h1, i[1]);
         porta = 8'hff;
         end_test("halt modes");
      end
      clrwdt = 1'b1;
      @(negedge clk);
      clrwdt = 1'b0;
      `CHK(power_down_flag, 1'b0)
      end_test("clear watchdog");
      // watchdog overflow out of sleep with the watchdog running
      wdt_en = 1'b1;
      halt_in(1'b0, 1'b0);
      wdt_ovf = 1'b1;
      @(negedge clk);
      wdt_ovf = 1'b0;
      wait_wake(2'h3, 1'b0);
      `CHK(tof, 1'b1)
      `CHK(power_down_flag, 1'b1)
      end_test("watchdog wake");
      // request already pending at entry is blind, a new masked one resumes
      irq_req = 8'h01;
      repeat (4) @(negedge clk);
      halt_in(1'b1, 1'b1);
      repeat (8) @(negedge clk);
      `CHK(core_halt, 1'b1)
      irq_req = 8'h03;
      wait_wake(2'h1, 1'b1);
      // enabled request: vector with free stack, resume with a full one
      for (int j = 0; j < 2; j++)
      begin
         irq_req = 8'h00;
         irq_en = 8'h02;
         stack_full = j[0];
         repeat (4) @(negedge clk);
         halt_in(1'b1, 1'b1);
         irq_req = 8'h02;
         wait_wake(j[0] ? 2'h1 : 2'h2, 1'b1);
         end_test("interrupt wake");
      end
      complete_run();
   end
endmodule
`default_nettype wire
